/* File: adcc_consts.svh */
// offsets, field positions, reset values and timing counts for the converter control block
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_OFF_CTRL 12'h000
`define ADCC_OFF_CORE 12'h004
`define ADCC_OFF_FMT 12'h008
`define ADCC_OFF_DMA 12'h00C
`define ADCC_CTRL_MASK 16'hB7FF
`define ADCC_CTRL_RESET 16'h0000
`define ADCC_BIT_ON 15
`define ADCC_BIT_IDLE 13
`define ADCC_BIT_DMA 12
`define ADCC_BIT_RES 10
`define ADCC_BIT_SIM 3
`define ADCC_BIT_AUTO_SAMPLE_START 2
`define ADCC_BIT_SAMPLE_HOLD_BIT 1
`define ADCC_BIT_DONE 0
`define ADCC_AUTO_CNT 8'h0F
`endif

/* File: adcc_core_model.sv */
// behavioural converter core answering conversion starts
`timescale 1ns/1ps
module adcc_core_model
  import adcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire adcc_core_t core_in,
  input wire logic [11:0] result_in,
  output logic done_out,
  output adcc_core_in_t core_out
);
  logic [1:0] cnt;
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in || !core_in.convert)
      cnt <= 2'h0;
    else if (cnt != 2'h3)
      cnt <= cnt + 2'h1;
  end
  assign done_out = (cnt == 2'h2);
  // result only valid with done, inverted otherwise so stale data shows
  assign core_out = '{done_out ? result_in : ~result_in, 4'h3, 4'h2, 8'h5A};
endmodule

/* File: adcc_monitor.sv */
// port checker for the converter control block
`timescale 1ns/1ps
module adcc_chk
  import adcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire adcc_core_t core_out,
  input wire logic [15:0] data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_ready_one_wait: assert property
    (psel_in && penable_in && ce_in && !pready_out |=> pready_out) else $error("late ready");
  a_ready_pulse: assert property
    (pready_out |=> !pready_out) else $error("ready too long");
  a_ready_cause: assert property
    (pready_out |-> $past(psel_in && penable_in)) else $error("ready without access");
  a_unmapped_err: assert property
    (pready_out && paddr_in > 12'h00C |-> pslverr_out) else $error("unmapped not refused");
  a_ctrl_no_err: assert property
    (pready_out && paddr_in == 12'h000 |-> !pslverr_out) else $error("control refused");
  a_unimpl_zero: assert property
    (pready_out && !pwrite_in && paddr_in == 12'h000 |-> prdata_out[14] == 1'b0
      && prdata_out[11] == 1'b0) else $error("unimplemented bit set");
  a_fmt_upper: assert property
    (data_out[15:12] == 4'h0 || data_out[15:12] == 4'hF) else $error("bad upper bits");
  a_start_ends_sample: assert property
    ($rose(core_out.convert) |-> $past(core_out.sample)) else $error("convert without sample");
endmodule
bind adcc_top adcc_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .core_out(core_out), .data_out(data_out));

/* File: adcc_pkg.sv */
// types for the converter control block
package adcc_pkg;
  typedef enum logic [2:0]
  {
    ADCC_SRC_MANUAL = 3'b000,
    ADCC_SRC_EXTINT = 3'b001,
    ADCC_SRC_TIMA = 3'b010,
    ADCC_SRC_RSV3 = 3'b011,
    ADCC_SRC_TIMB = 3'b100,
    ADCC_SRC_RSV5 = 3'b101,
    ADCC_SRC_RSV6 = 3'b110,
    ADCC_SRC_AUTO = 3'b111
  } adcc_src_t;
  typedef struct packed
  {
    logic sample;
    logic convert;
    logic twelve_bit;
  } adcc_core_t;
  typedef struct packed
  {
    logic [11:0] result;
    logic [3:0] analog_index;
    logic [3:0] buf_size_log2;
    logic [7:0] order_addr;
  } adcc_core_in_t;
endpackage

/* File: adcc_top.sv */
// converter control register one with apb access and conversion start logic
// Notes on behaviour
// [R01] adc_on high runs the module; low stops all sampling and conversion.
// [R02] idle_stop high halts the module while the device idles.
// [R03] dma_build_order high gives dma the same address as own result buffer.
// [R04] dma_build_order low gives scatter/gather address from input index and size.
// [R05] resolution_select high means 12-bit single channel, low 10-bit four channel.
// [R06] 10-bit: format 00 zero-extends, 01 fills top six with inverted bit 9.
// [R07] 12-bit: format 00 zero-extends, 01 fills top four with inverted bit 11.
// [R08] software must not use output_format codes 10 or 11.
// [R09] trigger source 111: internal counter ends sampling and starts conversion.
// [R10] source 100: timer five for instance one, timer three for instance two.
// [R11] source 010: timer three for instance one, timer five for instance two.
// [R12] source 001: active edge on external interrupt zero pin starts conversion.
// [R13] source 000: clearing sample_hold_bit ends sampling, starts conversion.
// [R14] software must not use trigger source codes 110, 101 or 011.
// [R15] bits 14 and 11 read zero and ignore writes.
// [R16] all implemented fields reset to zero.
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter bit INSTANCE_TWO = 1'b0
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic idle_mode_in,
  input wire logic timer_three_in,
  input wire logic timer_five_in,
  input wire logic external_interrupt_zero_pin_in,
  input wire logic core_done_in,
  input wire adcc_core_in_t core_in,
  output adcc_core_t core_out,
  output logic [15:0] data_out,
  output logic [7:0] dma_addr_out
);
  logic [1:0] pin_sync_r;
  logic [1:0] pin_sync_nxt;
  logic pin_prev_r;
  logic pin_prev_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic conv_r;
  logic conv_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [15:0] data_r;
  logic [15:0] data_nxt;
  logic [7:0] dma_r;
  logic [7:0] dma_nxt;
  logic running;
  logic trig;
  logic wr_ctrl;
  logic apb_acc;
  adcc_src_t src;
  logic run_gate;
  logic start;
  logic finish;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] fmt_result(input logic [11:0] d, input logic twelve,
                                             input logic [1:0] fmt);
    logic [15:0] v;
    v = 16'h0000;
    if (twelve)
    begin
      // [R07] twelve bit justify
      v = (fmt == 2'b01) ? {{4{~d[11]}}, d} : {4'h0, d};
    end
    else
    begin
      // [R06] ten bit justify
      v = (fmt == 2'b01) ? {{6{~d[9]}}, d[9:0]} : {6'h00, d[9:0]};
    end
    fmt_result = v;
  endfunction

  assign src = adcc_src_t'(ctrl_r[7:5]);
  // [R01] [R02] run gating
  assign running = ctrl_r[`ADCC_BIT_ON] & ~(ctrl_r[`ADCC_BIT_IDLE] & idle_mode_in);
  assign apb_acc = psel_in & penable_in & ~pready_r;
  assign wr_ctrl = apb_acc & pwrite_in & hit(paddr_in, `ADCC_OFF_CTRL);
  // every source needs an armed sample, manual included
  assign start = trig & ctrl_r[`ADCC_BIT_SAMPLE_HOLD_BIT];
  assign finish = conv_r & core_done_in;

  always_comb
  begin
    trig = 1'b0;
    unique case (src)
      // [R13] manual clear of sample
      ADCC_SRC_MANUAL: trig = wr_ctrl & pstrb_in[0] & ctrl_r[`ADCC_BIT_SAMPLE_HOLD_BIT]
                              & ~pwdata_in[`ADCC_BIT_SAMPLE_HOLD_BIT];
      // [R12] rising pin edge
      ADCC_SRC_EXTINT: trig = pin_sync_r[1] & ~pin_prev_r;
      // [R11] timer select a
      ADCC_SRC_TIMA: trig = INSTANCE_TWO ? timer_five_in : timer_three_in;
      // [R10] timer select b
      ADCC_SRC_TIMB: trig = INSTANCE_TWO ? timer_three_in : timer_five_in;
      // [R09] internal counter expiry
      ADCC_SRC_AUTO: trig = (cnt_r == `ADCC_AUTO_CNT);
      // reserved codes never start a conversion
      default: trig = 1'b0;
    endcase
  end

  // pin idles low and edge memory resets low, so no false edge after reset
  always_comb
  begin
    pin_sync_nxt = {pin_sync_r[0], external_interrupt_zero_pin_in};
    pin_prev_nxt = pin_sync_r[1];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_sync_r <= 2'b00;
      pin_prev_r <= 1'b0;
    end
    else if (ce_in)
    begin
      pin_sync_r <= pin_sync_nxt;
      pin_prev_r <= pin_prev_nxt;
    end
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      // [R15] unimplemented bits masked
      if (pstrb_in[1])
        ctrl_nxt[15:8] = pwdata_in[15:8];
      if (pstrb_in[0])
        ctrl_nxt[7:0] = {pwdata_in[7:5], 1'b0, pwdata_in[3:1], ctrl_r[0] & pwdata_in[0]};
      ctrl_nxt = ctrl_nxt & `ADCC_CTRL_MASK;
    end
    // judged on the new value so one write can switch on and arm sampling
    run_gate = ctrl_nxt[`ADCC_BIT_ON] & ~(ctrl_nxt[`ADCC_BIT_IDLE] & idle_mode_in);
    if (!run_gate)
    begin
      // [R01] [R02] off or idle-stopped drops sampling
      ctrl_nxt[`ADCC_BIT_SAMPLE_HOLD_BIT] = 1'b0;
    end
    else
    begin
      if (start)
        ctrl_nxt[`ADCC_BIT_SAMPLE_HOLD_BIT] = 1'b0;
      if (finish)
      begin
        // hardware set of done wins over the software clear
        ctrl_nxt[`ADCC_BIT_DONE] = 1'b1;
        ctrl_nxt[`ADCC_BIT_SAMPLE_HOLD_BIT] = ctrl_r[`ADCC_BIT_AUTO_SAMPLE_START];
      end
    end
  end

  always_comb
  begin
    cnt_nxt = 8'h00;
    conv_nxt = conv_r;
    if (!run_gate)
      conv_nxt = 1'b0;
    else
    begin
      // [R09] sampling time counted only in auto mode
      if (ctrl_nxt[`ADCC_BIT_SAMPLE_HOLD_BIT] && src == ADCC_SRC_AUTO)
        cnt_nxt = (cnt_r == `ADCC_AUTO_CNT) ? 8'h00 : cnt_r + 8'h01;
      if (start)
        conv_nxt = 1'b1;
      if (finish)
        conv_nxt = 1'b0;
    end
  end

  always_comb
  begin
    data_nxt = data_r;
    dma_nxt = dma_r;
    if (run_gate && finish)
    begin
      data_nxt = fmt_result(core_in.result, ctrl_r[`ADCC_BIT_RES], ctrl_r[9:8]);
      // [R03] [R04] dma address mode, widened before the shift
      dma_nxt = ctrl_r[`ADCC_BIT_DMA] ? core_in.order_addr
              : {4'h0, core_in.analog_index} << core_in.buf_size_log2;
    end
  end

  always_comb
  begin
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = apb_acc;
    if (apb_acc && !pwrite_in)
    begin
      prdata_nxt = 32'h0000_0000;
      if (hit(paddr_in, `ADCC_OFF_CTRL))
        prdata_nxt = {16'h0000, ctrl_r};
      else if (hit(paddr_in, `ADCC_OFF_CORE))
        prdata_nxt = {29'h0, conv_r, running, trig};
      else if (hit(paddr_in, `ADCC_OFF_FMT))
        prdata_nxt = {16'h0000, data_r};
      else if (hit(paddr_in, `ADCC_OFF_DMA))
        prdata_nxt = {24'h000000, dma_r};
      else
        pslverr_nxt = 1'b1;
    end
    else if (apb_acc && !hit(paddr_in, `ADCC_OFF_CTRL))
      pslverr_nxt = 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // [R16] zero at reset
      ctrl_r <= `ADCC_CTRL_RESET;
    end
    else if (ce_in)
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r <= 8'h00;
      conv_r <= 1'b0;
    end
    else if (ce_in)
    begin
      cnt_r <= cnt_nxt;
      conv_r <= conv_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      data_r <= 16'h0000;
      dma_r <= 8'h00;
    end
    else if (ce_in)
    begin
      data_r <= data_nxt;
      dma_r <= dma_nxt;
    end
  end

  // ready one wait state while ce_in stays high, simple to check at the cost of speed
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (ce_in)
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign data_out = data_r;
  assign dma_addr_out = dma_r;
  // [R05] resolution to core
  assign core_out = '{sample: ctrl_r[`ADCC_BIT_SAMPLE_HOLD_BIT], convert: conv_r,
                      twelve_bit: ctrl_r[`ADCC_BIT_RES]};
endmodule

/* File: testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench
  import adcc_pkg::*;
;
  logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, idle = 0, t3 = 0, t5 = 0, ext = 0;
  logic [11:0] addr = 0, res = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic rdy, err, e, done;
  adcc_core_t core;
  adcc_core_in_t cin;
  logic [15:0] dout;
  logic [7:0] dma;
  int errors = 0, comparisons = 0, n;
  logic [2:0] srcs [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
  always #50 clk_in = ~clk_in;
  adcc_top DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata), .pstrb_in(4'hF), .prdata_out(rdata),
    .pready_out(rdy), .pslverr_out(err), .idle_mode_in(idle), .timer_three_in(t3),
    .timer_five_in(t5), .external_interrupt_zero_pin_in(ext), .core_done_in(done),
    .core_in(cin), .core_out(core), .data_out(dout), .dma_addr_out(dma));
  adcc_core_model u_core (.clk_in(clk_in), .rst_in(rst_in), .core_in(core), .result_in(res),
    .done_out(done), .core_out(cin));
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer, held until ready is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    pen <= 1;
    n = 0;
    do @(posedge clk_in); while (rdy !== 1'b1 && ++n < 20);
    if (rdy !== 1'b1)
      errors++;
    rd = rdata;
    e = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk_in);
  endtask
  task automatic settle(input logic [15:0] ed, input logic [7:0] ea);
    n = 0;
    while (dout !== ed && n < 30)
    begin
      n++;
      @(posedge clk_in);
    end
    chk(dout, ed);
    chk(dma, ea);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    bus(0, 12'h000, 0);
    chk(rd, 0);
    bus(1, 12'h000, 32'hFD0A);
    bus(0, 12'h000, 0);
    chk(rd, 32'hB50A);
    res <= 12'h123;
    bus(1, 12'h000, 32'hFD08);
    settle(16'hF123, 8'h5A);
    idle <= 1;
    bus(1, 12'h000, 32'hFD0A);
    chk(core.sample, 0);
    idle <= 0;
    res <= 12'h0C5;
    bus(1, 12'h000, 32'h8102);
    bus(1, 12'h000, 32'h8100);
    settle(16'hFCC5, 8'h0C);
    bus(1, 12'h000, 32'h8002);
    bus(1, 12'h000, 32'h8000);
    settle(16'h00C5, 8'h0C);
    bus(1, 12'h000, 32'h0002);
    chk(core.sample, 0);
    // each pin, timer and auto trigger source, others held quiet
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 12'h000, 32'h8002 | (32'(srcs[i]) << 5));
      t3 <= (i == 1);
      t5 <= (i == 2);
      ext <= (i == 0);
      @(posedge clk_in);
      {t3, t5, ext} <= 3'h0;
      n = 0;
      while (core.convert !== 1'b1 && n < 40)
      begin
        n++;
        @(posedge clk_in);
      end
      chk(core.convert, 1);
      repeat (6) @(posedge clk_in);
    end
    bus(0, 12'h010, 0);
    chk(e, 1);
    end_of_test();
  end
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
